// [pkg/flash_cmd_pkg.sv]
package flash_cmd_pkg;

    // ************************************************************
    // widths and bus timing
    // ************************************************************
    localparam int ADDR_W = 20; // flash address pins
    localparam int DATA_W = 16; // flash data pins
    localparam int CLK_NS = 25; // 40 MHz system clock period
    localparam int CNT_W = 8; // width of phase counters

    // least time in ns -> whole cycles, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    localparam int T_SETUP_NS = 20; // address/data set up before strobe falls
    localparam int T_WP_NS = 40; // write strobe low time
    localparam int T_HOLD_NS = 30; // hold after strobe rises, chip enable still low
    localparam int SETUP_CYC = cyc_min(T_SETUP_NS);
    localparam int PULSE_CYC = cyc_min(T_WP_NS);
    localparam int HOLD_CYC = cyc_min(T_HOLD_NS);

    // ************************************************************
    // command addresses, data codes, field positions
    // ************************************************************
    localparam logic [19:0] ADDR_UNLOCK1 = 20'h00555; // first and third unlock address
    localparam logic [19:0] ADDR_UNLOCK2 = 20'h002aa; // second unlock address
    localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
    localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
    localparam logic [7:0] CODE_PROGRAM = 8'ha0;
    localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CODE_SECTOR = 8'h30;
    localparam logic [7:0] CODE_BLOCK = 8'h50;
    localparam logic [7:0] CODE_CHIP = 8'h10;
    localparam logic [7:0] CODE_SUSPEND = 8'hb0;
    localparam logic [7:0] CODE_RESUME = 8'h30;
    localparam logic [7:0] CODE_ID_QUERY = 8'h88;
    localparam logic [7:0] CODE_ID_PROGRAM = 8'ha5;
    localparam logic [7:0] CODE_ID_LOCK = 8'h85;
    localparam logic [7:0] CODE_PROD_ID = 8'h90;
    localparam logic [7:0] CODE_QUERY = 8'h98;
    localparam logic [7:0] CODE_EXIT = 8'hf0;
    localparam logic [15:0] LOCK_WORD = 16'h0000; // final lock-out data
    localparam int BANK_LSB = 18; // bank_select_bits are 19..18
    localparam int SECTOR_LSB = 11; // sector_select_address is 19..11
    localparam int BLOCK_LSB = 15; // block select is 19..15

    // ************************************************************
    // user command set
    // ************************************************************
    typedef enum logic [3:0] {
        CMD_PROGRAM,
        CMD_SECTOR_ERASE,
        CMD_BLOCK_ERASE,
        CMD_CHIP_ERASE,
        CMD_SUSPEND,
        CMD_RESUME,
        CMD_ID_QUERY,
        CMD_ID_PROGRAM,
        CMD_ID_LOCK,
        CMD_PROD_ID,
        CMD_QUERY,
        CMD_EXIT_LONG,
        CMD_EXIT_SHORT
    } cmd_t;

endpackage : flash_cmd_pkg

// [rtl/flash_write_cycle.sv]
`timescale 1ns/1ps
// one asynchronous bus write: setup, strobe low, hold, then release
module flash_write_cycle (
    input wire logic i_clk, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_start, // one-cycle request for a write
    input wire logic [19:0] i_addr, // address to place on the pins
    input wire logic [15:0] i_data, // data to place on the pins
    output logic [19:0] o_addr, // flash address pins
    output logic [15:0] o_dq, // flash data pins, driven value
    output logic o_dq_oe, // high while data pins are driven
    output logic o_ce_n, // chip enable, active low
    output logic o_we_n, // write strobe, active low
    output logic o_done // one-cycle pulse as the write ends
);

    typedef enum logic [1:0] {W_IDLE, W_SETUP, W_PULSE, W_HOLD} wr_phase_t;

    wr_phase_t phase; // where in the write we are
    logic [flash_cmd_pkg::CNT_W-1:0] cnt; // cycles left in the phase
    logic phase_end; // last cycle of current phase

    assign phase_end = (cnt == '0);

    // ************************************************************
    // phase sequencing
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase <= W_IDLE;
            cnt <= '0;
        end
        else
        begin
            unique case (phase)
                W_IDLE:
                begin
                    if (i_start)
                    begin
                        phase <= W_SETUP;
                        cnt <= flash_cmd_pkg::CNT_W'(flash_cmd_pkg::SETUP_CYC - 1);
                    end
                end
                W_SETUP:
                begin
                    if (phase_end)
                    begin
                        phase <= W_PULSE;
                        cnt <= flash_cmd_pkg::CNT_W'(flash_cmd_pkg::PULSE_CYC - 1);
                    end
                    else
                        cnt <= cnt - 1'b1;
                end
                W_PULSE:
                begin
                    if (phase_end)
                    begin
                        phase <= W_HOLD;
                        cnt <= flash_cmd_pkg::CNT_W'(flash_cmd_pkg::HOLD_CYC - 1);
                    end
                    else
                        cnt <= cnt - 1'b1;
                end
                W_HOLD:
                begin
                    if (phase_end)
                        phase <= W_IDLE;
                    else
                        cnt <= cnt - 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // pin drivers, all registered so nothing glitches on the bus
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_addr <= 20'h00000;
            o_dq <= 16'h0000;
            o_dq_oe <= 1'b0;
            o_ce_n <= 1'b1;
            o_we_n <= 1'b1;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= (phase == W_HOLD) && phase_end;
            if (phase == W_IDLE && i_start)
            begin
                // address and data are held for the whole write
                o_addr <= i_addr;
                o_dq <= i_data;
                o_ce_n <= 1'b0;
                o_dq_oe <= 1'b1;
            end
            else if (phase == W_SETUP && phase_end)
                o_we_n <= 1'b0; // device latches address on this fall
            else if (phase == W_PULSE && phase_end)
                o_we_n <= 1'b1; // device latches data on this rise
            else if (phase == W_HOLD && phase_end)
            begin
                o_ce_n <= 1'b1;
                o_dq_oe <= 1'b0;
            end
        end
    end

endmodule : flash_write_cycle

// [rtl/flash_cmd_host.sv]
`timescale 1ns/1ps
// Operation
// - program: two unlock writes, a0, then address/data
// - erase: five-write preamble, sixth selects kind
// - sixth write 30 erases one sector
// - sixth write 50 erases one block
// - sixth write 10 at 555 erases chip
// - single write b0 suspends erase
// - single write 30 resumes erase
// - unlock then 88 enters security id read
// - unlock, a5, then id word address/data
// - unlock, 85, then zero word locks id
// - unlock then 90 enters product id
// - unlock then 98 enters flash query
// - unlock then f0 leaves id modes
// - single write f0 leaves id modes
// - id lock-out only in word mode
// - host finishes all four id writes
module flash_cmd_host (
    input wire logic i_clk, // system clock, 40 MHz
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_cmd_valid, // user command request
    input wire flash_cmd_pkg::cmd_t i_cmd, // which command sequence
    input wire logic [19:0] i_addr, // target / sector / block / bank address
    input wire logic [15:0] i_data, // program data
    input wire logic i_byte_mode, // 1: device in 8-bit mode
    input wire logic i_flash_ready, // ready/busy pin, high when ready
    output logic o_cmd_ready, // command may be taken
    output logic o_cmd_done, // pulse: last write of sequence ended
    output logic o_cmd_error, // pulse: command refused
    output logic o_flash_ready, // synchronised ready/busy
    output logic [19:0] o_flash_addr, // flash address pins
    output logic [15:0] o_flash_dq, // flash data pins, driven value
    output logic o_flash_dq_oe, // high while data pins are driven
    output logic o_flash_ce_n, // chip enable
    output logic o_flash_we_n, // write enable
    output logic o_flash_oe_n, // output enable, held high
    output logic o_flash_rst_n, // hardware reset to the flash
    output logic o_flash_byte_n // width select, low for byte mode
);

    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} seq_state_t;

    seq_state_t state; // sequencer state
    seq_state_t next_state; // its next value
    flash_cmd_pkg::cmd_t cur_cmd; // command being issued
    logic [19:0] lat_addr; // user address taken with the command
    logic [15:0] lat_data; // user data taken with the command
    logic [2:0] step; // index of the current write
    logic [2:0] wr_count; // writes started in this command
    logic wr_start; // pulse into the write engine
    logic [19:0] wr_addr; // address for the next write
    logic [15:0] wr_data; // data for the next write
    logic wr_done; // write engine finished a write
    logic ready_meta; // first synchroniser stage
    logic accept; // command taken this cycle
    logic refuse; // command refused this cycle
    logic last_step; // current write closes the sequence

    // ************************************************************
    // sequence tables
    // ************************************************************
    function automatic logic [2:0] cmd_len(input flash_cmd_pkg::cmd_t c);
        unique case (c)
            flash_cmd_pkg::CMD_SUSPEND, flash_cmd_pkg::CMD_RESUME,
            flash_cmd_pkg::CMD_EXIT_SHORT: return 3'h1;
            flash_cmd_pkg::CMD_ID_QUERY, flash_cmd_pkg::CMD_PROD_ID,
            flash_cmd_pkg::CMD_QUERY, flash_cmd_pkg::CMD_EXIT_LONG: return 3'h3;
            flash_cmd_pkg::CMD_PROGRAM, flash_cmd_pkg::CMD_ID_PROGRAM,
            flash_cmd_pkg::CMD_ID_LOCK: return 3'h4;
            default: return 3'h6; // the three erases
        endcase
    endfunction : cmd_len

    function automatic logic is_erase(input flash_cmd_pkg::cmd_t c);
        return c inside {flash_cmd_pkg::CMD_SECTOR_ERASE, flash_cmd_pkg::CMD_BLOCK_ERASE,
                         flash_cmd_pkg::CMD_CHIP_ERASE};
    endfunction : is_erase

    // unlock writes keep the upper address at zero so the ignored pins sit at valid levels
    function automatic logic [19:0] step_addr(input flash_cmd_pkg::cmd_t c, input logic [2:0] s,
                                              input logic [19:0] ua);
        logic [2:0] fin;
        fin = cmd_len(c) - 3'h1;
        if (cmd_len(c) == 3'h1)
            return ua; // any address will do
        else if (s == fin && c != flash_cmd_pkg::CMD_CHIP_ERASE && (cmd_len(c) == 3'h4 || is_erase(c)))
            return ua; // target word, id word, sector or block
        else if (s == 3'h1 || s == 3'h4)
            return flash_cmd_pkg::ADDR_UNLOCK2;
        else if (s == 3'h2 && (c == flash_cmd_pkg::CMD_PROD_ID || c == flash_cmd_pkg::CMD_QUERY))
            return {ua[19:flash_cmd_pkg::BANK_LSB], flash_cmd_pkg::ADDR_UNLOCK1[17:0]};
        else
            return flash_cmd_pkg::ADDR_UNLOCK1;
    endfunction : step_addr

    function automatic logic [7:0] final_code(input flash_cmd_pkg::cmd_t c);
        unique case (c)
            flash_cmd_pkg::CMD_SECTOR_ERASE: return flash_cmd_pkg::CODE_SECTOR;
            flash_cmd_pkg::CMD_BLOCK_ERASE: return flash_cmd_pkg::CODE_BLOCK;
            flash_cmd_pkg::CMD_CHIP_ERASE: return flash_cmd_pkg::CODE_CHIP;
            flash_cmd_pkg::CMD_SUSPEND: return flash_cmd_pkg::CODE_SUSPEND;
            flash_cmd_pkg::CMD_RESUME: return flash_cmd_pkg::CODE_RESUME;
            flash_cmd_pkg::CMD_ID_QUERY: return flash_cmd_pkg::CODE_ID_QUERY;
            flash_cmd_pkg::CMD_PROD_ID: return flash_cmd_pkg::CODE_PROD_ID;
            flash_cmd_pkg::CMD_QUERY: return flash_cmd_pkg::CODE_QUERY;
            flash_cmd_pkg::CMD_PROGRAM: return flash_cmd_pkg::CODE_PROGRAM;
            flash_cmd_pkg::CMD_ID_PROGRAM: return flash_cmd_pkg::CODE_ID_PROGRAM;
            flash_cmd_pkg::CMD_ID_LOCK: return flash_cmd_pkg::CODE_ID_LOCK;
            default: return flash_cmd_pkg::CODE_EXIT; // both exits
        endcase
    endfunction : final_code

    // command bytes sit in the low lane, upper lane driven to zero
    function automatic logic [15:0] step_data(input flash_cmd_pkg::cmd_t c, input logic [2:0] s,
                                              input logic [15:0] ud);
        if (cmd_len(c) == 3'h4 && s == 3'h3)
            return (c == flash_cmd_pkg::CMD_ID_LOCK) ? flash_cmd_pkg::LOCK_WORD : ud;
        else if (cmd_len(c) == 3'h1 || s == cmd_len(c) - 3'h1 || (cmd_len(c) == 3'h4 && s == 3'h2))
            return {8'h00, final_code(c)};
        else if (is_erase(c) && s == 3'h2)
            return {8'h00, flash_cmd_pkg::CODE_ERASE_SETUP};
        else if (s == 3'h1 || s == 3'h4)
            return {8'h00, flash_cmd_pkg::CODE_UNLOCK2};
        else
            return {8'h00, flash_cmd_pkg::CODE_UNLOCK1};
    endfunction : step_data

    assign accept = i_cmd_valid && o_cmd_ready;
    assign refuse = accept && i_cmd == flash_cmd_pkg::CMD_ID_LOCK && i_byte_mode;
    assign last_step = (step == cmd_len(cur_cmd) - 3'h1);

    // ************************************************************
    // sequencer: every started sequence runs to its last write
    // ************************************************************
    always_comb
    begin
        next_state = state;
        unique case (state)
            S_IDLE:
                if (accept && !refuse)
                    next_state = S_ISSUE;
            S_ISSUE:
                next_state = S_WAIT;
            S_WAIT:
                if (wr_done)
                    next_state = last_step ? S_IDLE : S_ISSUE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state <= S_IDLE;
        else
            state <= next_state;
    end

    // command capture and step index
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cur_cmd <= flash_cmd_pkg::CMD_EXIT_SHORT;
            lat_addr <= 20'h00000;
            lat_data <= 16'h0000;
            step <= 3'h0;
            o_flash_byte_n <= 1'b1;
        end
        else if (state == S_IDLE && accept && !refuse)
        begin
            cur_cmd <= i_cmd;
            lat_addr <= i_addr;
            lat_data <= i_data;
            step <= 3'h0;
            o_flash_byte_n <= !i_byte_mode;
        end
        else if (state == S_WAIT && wr_done && !last_step)
            step <= step + 3'h1;
    end

    // write request, one per step
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_start <= 1'b0;
            wr_addr <= 20'h00000;
            wr_data <= 16'h0000;
            wr_count <= 3'h0;
        end
        else
        begin
            wr_start <= (state == S_ISSUE);
            if (state == S_ISSUE)
            begin
                wr_addr <= step_addr(cur_cmd, step, lat_addr);
                wr_data <= step_data(cur_cmd, step, lat_data);
            end
            if (accept)
                wr_count <= 3'h0;
            else if (wr_start)
                wr_count <= wr_count + 3'h1;
        end
    end

    // user handshake flags
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_cmd_ready <= 1'b0;
            o_cmd_done <= 1'b0;
            o_cmd_error <= 1'b0;
        end
        else
        begin
            o_cmd_ready <= (next_state == S_IDLE) && !(accept && !refuse);
            o_cmd_done <= (state == S_WAIT) && wr_done && last_step;
            o_cmd_error <= refuse;
        end
    end

    // ready/busy pin synchroniser; flash reset released one edge after ours
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ready_meta <= 1'b0;
            o_flash_ready <= 1'b0;
            o_flash_rst_n <= 1'b0;
            o_flash_oe_n <= 1'b1;
        end
        else
        begin
            ready_meta <= i_flash_ready;
            o_flash_ready <= ready_meta;
            o_flash_rst_n <= 1'b1;
            o_flash_oe_n <= 1'b1; // no reads are made here
        end
    end

    flash_write_cycle u_write (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_start(wr_start),
        .i_addr(wr_addr),
        .i_data(wr_data),
        .o_addr(o_flash_addr),
        .o_dq(o_flash_dq),
        .o_dq_oe(o_flash_dq_oe),
        .o_ce_n(o_flash_ce_n),
        .o_we_n(o_flash_we_n),
        .o_done(wr_done)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_prog_command: assert property ($fell(o_flash_we_n) && cur_cmd == flash_cmd_pkg::CMD_PROGRAM && step == 3'h2
        |-> o_flash_addr == 20'h00555 && o_flash_dq == 16'h00a0) else $error("bad program code write");
    a_erase_setup: assert property ($fell(o_flash_we_n) && is_erase(cur_cmd) && step == 3'h2
        |-> o_flash_dq == 16'h0080) else $error("bad erase setup write");
    a_sector_pick: assert property ($fell(o_flash_we_n) && cur_cmd == flash_cmd_pkg::CMD_SECTOR_ERASE && step == 3'h5
        |-> o_flash_dq == 16'h0030 && o_flash_addr[19:11] == lat_addr[19:11]) else $error("bad sector write");
    a_block_pick: assert property ($fell(o_flash_we_n) && cur_cmd == flash_cmd_pkg::CMD_BLOCK_ERASE && step == 3'h5
        |-> o_flash_dq == 16'h0050 && o_flash_addr[19:15] == lat_addr[19:15]) else $error("bad block write");
    a_chip_erase: assert property ($fell(o_flash_we_n) && cur_cmd == flash_cmd_pkg::CMD_CHIP_ERASE && step == 3'h5
        |-> o_flash_addr == 20'h00555 && o_flash_dq == 16'h0010) else $error("bad chip erase write");
    a_single_write: assert property (o_cmd_done && cmd_len(cur_cmd) == 3'h1
        |-> wr_count == 3'h1 && $past(o_flash_dq, 6) inside {16'h00b0, 16'h0030, 16'h00f0})
        else $error("single-write command wrong");
    a_mode_entry: assert property ($fell(o_flash_we_n) && step == 3'h2 && cur_cmd inside
        {flash_cmd_pkg::CMD_PROD_ID, flash_cmd_pkg::CMD_QUERY} |-> o_flash_addr[19:18] == lat_addr[19:18]
        && o_flash_addr[10:0] == 11'h555) else $error("bad bank entry write");
    a_id_lock_word: assert property ($fell(o_flash_we_n) && cur_cmd == flash_cmd_pkg::CMD_ID_LOCK && step == 3'h3
        |-> o_flash_dq == 16'h0000) else $error("lock word not zero");
    a_full_length: assert property (o_cmd_done |-> wr_count == cmd_len(cur_cmd))
        else $error("sequence cut short");
    a_unlock_levels: assert property ($fell(o_flash_we_n) && !last_step
        |-> o_flash_dq[15:8] == 8'h00 && o_flash_addr[17:11] == 7'h00) else $error("unlock pins not clean");
    a_lock_refused: assert property (accept && i_cmd == flash_cmd_pkg::CMD_ID_LOCK && i_byte_mode
        |=> o_cmd_error && state == S_IDLE) else $error("byte-mode lock not refused");
    a_write_bound: assert property (wr_start |-> ##[1:12] wr_done) else $error("write cycle hung");

    c_program: cover property (o_cmd_done && cur_cmd == flash_cmd_pkg::CMD_PROGRAM);
    c_sector_erase: cover property (o_cmd_done && cur_cmd == flash_cmd_pkg::CMD_SECTOR_ERASE);
    c_suspend: cover property (o_cmd_done && cur_cmd == flash_cmd_pkg::CMD_SUSPEND);
    c_refused: cover property (o_cmd_error);

endmodule : flash_cmd_host

// [bench/flash_dev_model.sv]
`timescale 1ns/1ps
// behavioural flash device: decodes command writes seen on its pins
module flash_dev_model (
    input wire logic i_rst_n, // flash reset, active low
    input wire logic [19:0] i_addr, // address pins
    input wire logic [15:0] i_dq, // data pins
    input wire logic i_ce_n, // chip enable
    input wire logic i_we_n, // write strobe
    input wire logic i_byte_n, // low for byte mode
    output logic o_ready // ready/busy, pulled up
);
    // ****
    // decoder state
    // ****
    int step = 0; // place within a sequence
    int s; // step of the current write
    int writes = 0; // completed writes
    int last_cmd = -1; // last command recognised, in cmd_t order
    logic [35:0] last = '0; // {address, data} of its final write
    logic [7:0] d; // compared data byte
    initial o_ready = 1'b1;
    // low address compare; upper bits are don't-care
    function automatic logic at(input logic [10:0] k);
        return ((i_addr[10:0] ^ k) & (i_byte_n ? 11'h7ff : 11'h7fd)) == 11'h000;
    endfunction : at
    // close a sequence; program and erase hold busy a while
    task automatic hit(input int c);
        last_cmd = c;
        last = {i_addr, i_dq};
        if (c <= 3) o_ready = 1'b0;
        if (c <= 3) o_ready <= #200 1'b1;
    endtask : hit
    always @(negedge i_rst_n) step = 0; // back to array reads
    // latched as the strobe rises with chip enabled
    always @(posedge i_we_n)
    begin
        if (!i_ce_n)
        begin
            d = i_dq[7:0];
            writes++;
            s = step;
            step = 0;
            case (s)
                0: if (at(11'h555) && d == 8'haa) step = 1;
                   else if (d == 8'hb0) hit(4);
                   else if (d == 8'h30) hit(5);
                   else if (d == 8'hf0) hit(12);
                1: if (at(11'h2aa) && d == 8'h55) step = 2;
                2: if (at(11'h555))
                   case (d)
                       8'ha0: step = 3;
                       8'ha5: step = 4;
                       8'h85: step = 5;
                       8'h80: step = 6;
                       8'h88: hit(6);
                       8'h90: hit(9);
                       8'h98: hit(10);
                       8'hf0: hit(11);
                       default: step = 0;
                   endcase
                3: hit(0);
                4: hit(7);
                5: if (i_dq == 16'h0000) hit(8);
                6: if (at(11'h555) && d == 8'haa) step = 7;
                7: if (at(11'h2aa) && d == 8'h55) step = 8;
                8: if (d == 8'h30) hit(1);
                   else if (d == 8'h50) hit(2);
                   else if (d == 8'h10 && at(11'h555)) hit(3);
                default: step = 0;
            endcase
        end
    end
endmodule : flash_dev_model

// [bench/test_flash_cmd_host.sv]
`timescale 1ns/1ps
// bench: host controller against the behavioural device
module test_flash_cmd_host;
    logic i_clk = 1'b0; // 40 MHz
    logic i_rst_n = 1'b0; // reset, active low
    logic i_cmd_valid = 1'b0; // request
    flash_cmd_pkg::cmd_t i_cmd = flash_cmd_pkg::CMD_PROGRAM; // sequence
    logic [19:0] i_addr = 20'hc3a5c; // bank bits 11, odd low bits
    logic [15:0] i_data = 16'h5aa5; // program data
    logic i_byte_mode = 1'b0; // word mode
    logic o_cmd_ready, o_cmd_done, o_cmd_error, o_flash_ready, ready_pin;
    logic [19:0] o_flash_addr;
    logic [15:0] o_flash_dq;
    logic o_flash_dq_oe, o_flash_ce_n, o_flash_we_n, o_flash_oe_n, o_flash_rst_n, o_flash_byte_n;
    int miscompares = 0; // mismatches
    int checks = 0; // comparisons
    int cycles = 0; // watchdog
    // ****
    // expected {last address, last data, writes} per command, cmd_t order
    // ****
    logic [43:0] tab [13] = '{44'hc3a5c_5aa5_04, 44'hc3a5c_0030_06, 44'hc3a5c_0050_06, 44'h00555_0010_06,
        44'hc3a5c_00b0_01, 44'hc3a5c_0030_01, 44'h00555_0088_03, 44'hc3a5c_5aa5_04, 44'hc3a5c_0000_04,
        44'hc0555_0090_03, 44'hc0555_0098_03, 44'h00555_00f0_03, 44'hc3a5c_00f0_01};
    flash_cmd_host DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_addr(i_addr),
        .i_data(i_data), .i_byte_mode(i_byte_mode), .i_flash_ready(ready_pin), .o_cmd_ready(o_cmd_ready),
        .o_cmd_done(o_cmd_done), .o_cmd_error(o_cmd_error), .o_flash_ready(o_flash_ready),
        .o_flash_addr(o_flash_addr), .o_flash_dq(o_flash_dq), .o_flash_dq_oe(o_flash_dq_oe),
        .o_flash_ce_n(o_flash_ce_n), .o_flash_we_n(o_flash_we_n), .o_flash_oe_n(o_flash_oe_n),
        .o_flash_rst_n(o_flash_rst_n), .o_flash_byte_n(o_flash_byte_n));
    flash_dev_model dev (.i_rst_n(o_flash_rst_n), .i_addr(o_flash_addr), .i_dq(o_flash_dq), .i_ce_n(o_flash_ce_n),
        .i_we_n(o_flash_we_n), .i_byte_n(o_flash_byte_n), .o_ready(ready_pin));
    initial forever #12.5 i_clk = ~i_clk;
    // hang guard: the full run needs well under 2000 cycles
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [43:0] seen, input logic [43:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // one command from a falling edge; latency, write count and decode judged
    task automatic issue(input int i, input int nw);
        int w0;
        int n;
        w0 = dev.writes;
        for (n = 0; n < 200 && o_cmd_ready !== 1'b1; n++) @(negedge i_clk);
        i_cmd = flash_cmd_pkg::cmd_t'(i);
        i_cmd_valid = 1'b1;
        @(negedge i_clk);
        i_cmd_valid = 1'b0;
        for (n = 1; n < 100 && o_cmd_done !== 1'b1 && o_cmd_error !== 1'b1; n++) @(negedge i_clk);
        check(n, 1 + 8 * nw);
        check(dev.writes - w0, nw);
        check(o_cmd_error, nw == 0);
        if (nw > 0) check({dev.last_cmd[7:0], dev.last}, {8'(i), tab[i][43:8]});
        if (nw > 0) check(o_flash_ready, i > 3);
    endtask : issue
    // every command back to back in word mode
    task automatic t_all_commands();
        for (int i = 0; i < 13; i++) issue(i, tab[i][7:0]);
    endtask : t_all_commands
    // byte mode: width pin follows, lock-out refused without writes
    task automatic t_byte_mode();
        i_byte_mode = 1'b1;
        issue(0, 4);
        check(o_flash_byte_n, 1'b0);
        issue(8, 0);
        i_byte_mode = 1'b0;
    endtask : t_byte_mode
    // reset in mid-erase, then a fresh program is still recognised
    task automatic t_reset_mid();
        i_cmd = flash_cmd_pkg::CMD_CHIP_ERASE;
        i_cmd_valid = 1'b1;
        // lands after the third strobe rise, chip enable still low, so no strobe edge races the reset
        repeat (22) @(negedge i_clk);
        i_cmd_valid = 1'b0;
        i_rst_n = 1'b0;
        @(negedge i_clk);
        check({o_flash_ce_n, o_flash_we_n, o_flash_rst_n}, 3'b110);
        i_rst_n = 1'b1;
        issue(0, 4);
    endtask : t_reset_mid
    initial
    begin
        repeat (20) @(negedge i_clk);
        i_rst_n = 1'b1;
        check({o_flash_oe_n, o_flash_byte_n, o_flash_ce_n, o_flash_dq_oe}, 4'b1110);
        t_all_commands();
        t_byte_mode();
        t_reset_mid();
        tally_and_finish();
    end
endmodule : test_flash_cmd_host
